// ==== hw/sdwr_device.sv ====
/*
 * Receive-only SMBus slave of a 10-bit converter: word write, send
 * byte, synchronisation quick command, stop and sync updates.
 * Assumes the master drives the bus clock; lines arrive unsynchronised.
 */
`timescale 1ns/1ps

// Functional notes
// - Low data byte gives code bits 7..0
// - High byte bits 1..0 are code 9..8
// - Address plus command only is valid write
// - Command-only write never carries code bits
// - Abort after command ack keeps command only
// - Abort before command ack drops command
// - Also answer the shared synchronisation address
// - Sync address 1111110, quick command flag
// - Sync flag high updates only if selected
// - Sync flag low always clears device
// - Word write: acknowledge and latch each byte
// - Stop copies inputs to outputs unless sync-only
// - Command bit 0 chooses sync-only updating
// - Sync update lands on acknowledge clock rise
module sdwr_device
  import sdwr_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEF
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  sdwr_if.device          BUS,
  output logic [9:0]      CODE,
  output logic            PWRDN,
  output logic            BGREF
);

  // ********************************************************
  // Line synchronisers and bus conditions
  // ********************************************************
  // Stage 0 feeds stage 1 only; stages 1 and 2 give level and history
  logic [2:0] scl_q_r;
  logic [2:0] sda_q_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  assign scl_rise  = scl_q_r[1] & ~scl_q_r[2];
  assign scl_fall  = ~scl_q_r[1] & scl_q_r[2];
  assign bus_start = scl_q_r[1] & scl_q_r[2] & sda_q_r[2] & ~sda_q_r[1];
  assign bus_stop  = scl_q_r[1] & scl_q_r[2] & ~sda_q_r[2] & sda_q_r[1];

  // ********************************************************
  // Receiver state
  // ********************************************************
  sdwr_dst_t  st_r,     st_nxt;
  logic [7:0] shift_r,  shift_nxt;
  logic [3:0] bit_r,    bit_nxt;
  logic [1:0] idx_r,    idx_nxt;
  logic       own_r,    own_nxt;
  logic       sync_r,   sync_nxt;
  logic       flag_r,   flag_nxt;
  logic       sda_oe_r, sda_oe_nxt;
  logic [2:0] cmd_r,    cmd_nxt;
  logic [7:0] lowp_r,   lowp_nxt;
  logic [7:0] low_in_r, low_in_nxt;
  logic [1:0] hi_in_r,  hi_in_nxt;
  logic [9:0] code_r,   code_nxt;
  logic       pwrdn_r,  pwrdn_nxt;
  logic       bgref_r,  bgref_nxt;

  always_comb begin
    st_nxt     = st_r;
    shift_nxt  = shift_r;
    bit_nxt    = bit_r;
    idx_nxt    = idx_r;
    own_nxt    = own_r;
    sync_nxt   = sync_r;
    flag_nxt   = flag_r;
    sda_oe_nxt = sda_oe_r;
    cmd_nxt    = cmd_r;
    lowp_nxt   = lowp_r;
    low_in_nxt = low_in_r;
    hi_in_nxt  = hi_in_r;
    code_nxt   = code_r;
    pwrdn_nxt  = pwrdn_r;
    bgref_nxt  = bgref_r;
    if (bus_start) begin
      // A restart drops any unacknowledged byte and pending low data
      st_nxt     = D_RECV;
      bit_nxt    = 4'h0;
      idx_nxt    = 2'h0;
      own_nxt    = 1'b0;
      sync_nxt   = 1'b0;
      sda_oe_nxt = 1'b0;
    end else if (bus_stop) begin
      st_nxt     = D_IDLE;
      sda_oe_nxt = 1'b0;
      own_nxt    = 1'b0;
      sync_nxt   = 1'b0;
      if (own_r && !cmd_r[CMD_SY]) begin
        code_nxt  = {hi_in_r, low_in_r};
        pwrdn_nxt = cmd_r[CMD_SD];
        bgref_nxt = cmd_r[CMD_BG];
      end
    end else begin
      unique case (st_r)
        D_IDLE: begin
        end
        D_RECV: begin
          if (scl_rise && bit_r != 4'h8) begin
            shift_nxt = {shift_r[6:0], sda_q_r[1]};
            bit_nxt   = bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            st_nxt     = D_ACK;
            sda_oe_nxt = 1'b1;
            if (idx_r == 2'h0) begin
              if (shift_r[7:1] == OWN_ADDR && !shift_r[0]) begin
                own_nxt = 1'b1;
              end else if (shift_r[7:1] == SYNC_ADDR) begin
                sync_nxt = 1'b1;
                flag_nxt = shift_r[0];
              end else begin
                st_nxt     = D_IDLE;
                sda_oe_nxt = 1'b0;
              end
            end else if (!own_r) begin
              // Bytes after a quick command are not ours to answer
              st_nxt     = D_IDLE;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        D_ACK: begin
          if (scl_rise) begin
            if (sync_r) begin
              if (!flag_r) begin
                cmd_nxt    = CMD_RST;
                lowp_nxt   = 8'h00;
                low_in_nxt = CODE_RST[7:0];
                hi_in_nxt  = CODE_RST[9:8];
                code_nxt   = CODE_RST;
                pwrdn_nxt  = 1'b0;
                bgref_nxt  = 1'b0;
              end else if (cmd_r[CMD_SY]) begin
                code_nxt  = {hi_in_r, low_in_r};
                pwrdn_nxt = cmd_r[CMD_SD];
                bgref_nxt = cmd_r[CMD_BG];
              end
            end else begin
              unique case (idx_r)
                2'h0: begin
                end
                // Settings change only once the command byte is acked
                2'h1: cmd_nxt = shift_r[2:0];
                // Low byte waits for the high byte's ack before it counts
                2'h2: lowp_nxt = shift_r;
                2'h3: begin
                  low_in_nxt = lowp_r;
                  hi_in_nxt  = shift_r[1:0];
                end
              endcase
            end
          end else if (scl_fall) begin
            sda_oe_nxt = 1'b0;
            bit_nxt    = 4'h0;
            idx_nxt    = idx_r + 2'h1;
            st_nxt     = (sync_r || idx_r == 2'h3) ? D_IDLE : D_RECV;
          end
        end
        default: begin
          st_nxt     = D_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      scl_q_r      <= 3'h7;
      sda_q_r      <= 3'h7;
      st_r         <= D_IDLE;
      shift_r      <= 8'h00;
      bit_r        <= 4'h0;
      idx_r        <= 2'h0;
      own_r        <= 1'b0;
      sync_r       <= 1'b0;
      flag_r       <= 1'b0;
      sda_oe_r     <= 1'b0;
      cmd_r        <= CMD_RST;
      lowp_r       <= 8'h00;
      low_in_r     <= CODE_RST[7:0];
      hi_in_r      <= CODE_RST[9:8];
      code_r       <= CODE_RST;
      pwrdn_r      <= 1'b0;
      bgref_r      <= 1'b0;
      BUS.sda_d_o  <= 1'b0;
      BUS.sda_d_oe <= 1'b0;
      CODE         <= CODE_RST;
      PWRDN        <= 1'b0;
      BGREF        <= 1'b0;
    end else begin
      scl_q_r      <= {scl_q_r[1:0], BUS.scl};
      sda_q_r      <= {sda_q_r[1:0], BUS.sda};
      st_r         <= st_nxt;
      shift_r      <= shift_nxt;
      bit_r        <= bit_nxt;
      idx_r        <= idx_nxt;
      own_r        <= own_nxt;
      sync_r       <= sync_nxt;
      flag_r       <= flag_nxt;
      sda_oe_r     <= sda_oe_nxt;
      cmd_r        <= cmd_nxt;
      lowp_r       <= lowp_nxt;
      low_in_r     <= low_in_nxt;
      hi_in_r      <= hi_in_nxt;
      code_r       <= code_nxt;
      pwrdn_r      <= pwrdn_nxt;
      bgref_r      <= bgref_nxt;
      BUS.sda_d_o  <= 1'b0;
      BUS.sda_d_oe <= sda_oe_nxt;
      CODE         <= code_nxt;
      PWRDN        <= pwrdn_nxt;
      BGREF        <= bgref_nxt;
    end
  end

endmodule : sdwr_device

// ==== hw/sdwr_host.sv ====
/*
 * SMBus master for the converter: AXI4-Lite registers take a target,
 * command, code and transfer kind, then the engine runs the frame.
 * Assumes the slave never stretches the bus clock.
 */
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module sdwr_host
  import sdwr_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  sdwr_if.host             BUS
);

  function automatic logic [5:0] reg_hit(input logic [7:0] a);
    reg_hit = {a == REG_STATUS, a == REG_CODE, a == REG_CMD, a == REG_TARGET, a == REG_CTRL,
               a inside {REG_CTRL, REG_TARGET, REG_CMD, REG_CODE, REG_STATUS}};
  endfunction : reg_hit

  // ********************************************************
  // Register slave and frame engine
  // ********************************************************
  logic       sda_q1_r, sda_q2_r;
  logic       aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic       bv_nxt, rv_nxt;
  logic [1:0] br_nxt, rr_nxt;
  logic [31:0] rd_nxt;
  logic [6:0] tgt_r, tgt_nxt;
  logic [2:0] cmd_r, cmd_nxt;
  logic [9:0] code_r, code_nxt;
  logic       nack_r, nack_nxt;
  sdwr_hst_t  st_r, st_nxt;
  logic [9:0] tc_r, tc_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [1:0] byte_r, byte_nxt, last_r, last_nxt;
  logic [7:0] frame_r [4];
  logic [7:0] frame_nxt [4];
  logic       scl_oe_nxt, sda_oe_nxt;
  logic [5:0] hw, hr;
  logic       tick;

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awa_nxt    = awa_r;
    wd_nxt     = wd_r;
    ws_nxt     = ws_r;
    bv_nxt     = BVALID & ~BREADY;
    br_nxt     = BRESP;
    rv_nxt     = RVALID & ~RREADY;
    rr_nxt     = RRESP;
    rd_nxt     = RDATA;
    tgt_nxt    = tgt_r;
    cmd_nxt    = cmd_r;
    code_nxt   = code_r;
    nack_nxt   = nack_r;
    st_nxt     = st_r;
    ph_nxt     = ph_r;
    bit_nxt    = bit_r;
    byte_nxt   = byte_r;
    last_nxt   = last_r;
    frame_nxt  = frame_r;
    scl_oe_nxt = BUS.scl_h_oe;
    sda_oe_nxt = BUS.sda_h_oe;
    tick       = tc_r == QTR_LAST;
    tc_nxt     = (st_r == H_IDLE || tick) ? 10'h000 : tc_r + 10'h001;
    if (AWVALID && AWREADY) begin
      aw_got_nxt = 1'b1;
      awa_nxt    = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_got_nxt = 1'b1;
      wd_nxt    = WDATA;
      ws_nxt    = WSTRB;
    end
    hw = reg_hit(awa_r);
    if (aw_got_r && w_got_r && !BVALID) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bv_nxt     = 1'b1;
      br_nxt     = hw[0] ? RESP_OKAY : RESP_DEC;
      if (ws_r[0]) begin
        if (hw[2]) tgt_nxt = wd_r[6:0];
        if (hw[3]) cmd_nxt = wd_r[2:0];
        if (hw[4]) code_nxt[7:0] = wd_r[7:0];
        // A start request while a frame runs is dropped
        if (hw[1] && wd_r[CTRL_GO] && st_r == H_IDLE &&
            wd_r[CTRL_KIND+:2] != 2'b11) begin
          st_nxt       = H_START;
          ph_nxt       = 2'h0;
          nack_nxt     = 1'b0;
          frame_nxt[0] = (wd_r[CTRL_KIND+:2] == K_QUICK) ? {SYNC_ADDR, wd_r[CTRL_FLAG]} : {tgt_r, 1'b0};
          frame_nxt[1] = {5'h00, cmd_r};
          frame_nxt[2] = code_r[7:0];
          frame_nxt[3] = {6'h00, code_r[9:8]};
          last_nxt     = (wd_r[CTRL_KIND+:2] == K_WORD) ? 2'h3 : wd_r[CTRL_KIND+:2];
        end
      end
      if (ws_r[1] && hw[4]) code_nxt[9:8] = wd_r[9:8];
    end
    hr = reg_hit(ARADDR);
    if (ARVALID && ARREADY) begin
      rv_nxt = 1'b1;
      rr_nxt = hr[0] ? RESP_OKAY : RESP_DEC;
      rd_nxt = 32'h0000_0000;
      if (hr[2]) rd_nxt[6:0] = tgt_r;
      if (hr[3]) rd_nxt[2:0] = cmd_r;
      if (hr[4]) rd_nxt[9:0] = code_r;
      if (hr[5]) rd_nxt[STAT_NACK:STAT_BUSY] = {nack_r, st_r != H_IDLE};
    end
    if (tick) begin
      ph_nxt = ph_r + 2'h1;
      unique case (st_r)
        H_IDLE: begin
        end
        H_START: begin
          if (ph_r == 2'h0) sda_oe_nxt = 1'b1;
          if (ph_r == 2'h1) begin
            scl_oe_nxt = 1'b1;
            st_nxt     = H_BIT;
            ph_nxt     = 2'h0;
            bit_nxt    = 4'h0;
            byte_nxt   = 2'h0;
          end
        end
        H_BIT: begin
          unique case (ph_r)
            2'h0: sda_oe_nxt = (bit_r == 4'h8) ? 1'b0 : ~frame_r[byte_r][3'h7 - bit_r[2:0]];
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: if (bit_r == 4'h8 && sda_q2_r) nack_nxt = 1'b1;
            2'h3: begin
              scl_oe_nxt = 1'b1;
              bit_nxt    = bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                bit_nxt  = 4'h0;
                byte_nxt = byte_r + 2'h1;
                if (nack_r || byte_r == last_r) st_nxt = H_STOP;
              end
            end
          endcase
        end
        H_STOP: begin
          if (ph_r == 2'h0) sda_oe_nxt = 1'b1;
          if (ph_r == 2'h1) scl_oe_nxt = 1'b0;
          if (ph_r == 2'h2) begin
            sda_oe_nxt = 1'b0;
            st_nxt     = H_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sda_q1_r <= 1'b1;
      sda_q2_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awa_r    <= 8'h00;
      wd_r     <= 32'h0000_0000;
      ws_r     <= 4'h0;
      AWREADY  <= 1'b0;
      WREADY   <= 1'b0;
      BVALID   <= 1'b0;
      BRESP    <= RESP_OKAY;
      ARREADY  <= 1'b0;
      RVALID   <= 1'b0;
      RRESP    <= RESP_OKAY;
      RDATA    <= 32'h0000_0000;
      tgt_r    <= OWN_ADDR_DEF;
      cmd_r    <= CMD_RST;
      code_r   <= CODE_RST;
      nack_r   <= 1'b0;
      st_r     <= H_IDLE;
      tc_r     <= 10'h000;
      ph_r     <= 2'h0;
      bit_r    <= 4'h0;
      byte_r   <= 2'h0;
      last_r   <= 2'h0;
      frame_r  <= '{default: 8'h00};
      BUS.scl_h_o  <= 1'b0;
      BUS.sda_h_o  <= 1'b0;
      BUS.scl_h_oe <= 1'b0;
      BUS.sda_h_oe <= 1'b0;
    end else begin
      sda_q1_r <= BUS.sda;
      sda_q2_r <= sda_q1_r;
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awa_r    <= awa_nxt;
      wd_r     <= wd_nxt;
      ws_r     <= ws_nxt;
      AWREADY  <= ~aw_got_nxt & ~bv_nxt;
      WREADY   <= ~w_got_nxt & ~bv_nxt;
      BVALID   <= bv_nxt;
      BRESP    <= br_nxt;
      ARREADY  <= ~rv_nxt;
      RVALID   <= rv_nxt;
      RRESP    <= rr_nxt;
      RDATA    <= rd_nxt;
      tgt_r    <= tgt_nxt;
      cmd_r    <= cmd_nxt;
      code_r   <= code_nxt;
      nack_r   <= nack_nxt;
      st_r     <= st_nxt;
      tc_r     <= tc_nxt;
      ph_r     <= ph_nxt;
      bit_r    <= bit_nxt;
      byte_r   <= byte_nxt;
      last_r   <= last_nxt;
      frame_r  <= frame_nxt;
      BUS.scl_h_o  <= 1'b0;
      BUS.sda_h_o  <= 1'b0;
      BUS.scl_h_oe <= scl_oe_nxt;
      BUS.sda_h_oe <= sda_oe_nxt;
    end
  end

endmodule : sdwr_host

// ==== hw/sdwr_if.sv ====
/*
 * Two-wire link between the controller and the converter receiver.
 * Assumes open-drain wires with pull-ups: a line is low while any
 * party enables its driver.
 */
`timescale 1ns/1ps
interface sdwr_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  wire  scl;
  wire  sda;

  assign scl = scl_h_oe ? scl_h_o : 1'b1;
  assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);

  modport device (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (input scl, input sda, output scl_h_o, output scl_h_oe,
                output sda_h_o, output sda_h_oe);
endinterface : sdwr_if

// ==== hw/sdwr_pkg.sv ====
/*
 * Shared constants for the SMBus converter write link: addresses,
 * command field positions, state codes and controller register map.
 * Assumes both ends and the bench import it whole.
 */
package sdwr_pkg;

  // ********************************************************
  // Bus addresses and command byte fields
  // ********************************************************
  localparam logic [6:0] SYNC_ADDR    = 7'h7e;
  localparam logic [6:0] OWN_ADDR_DEF = 7'h20;
  localparam int         CMD_SY       = 0;
  localparam int         CMD_SD       = 1;
  localparam int         CMD_BG       = 2;
  localparam logic [2:0] CMD_RST      = 3'h0;
  localparam logic [9:0] CODE_RST     = 10'h000;

  // ********************************************************
  // Link timing
  // ********************************************************
  localparam int         CLK_PERIOD_NS = 5;
  localparam int         SCL_PERIOD_NS = 10000;
  localparam int         QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [9:0] QTR_LAST      = 10'(QTR_CYC - 1);

  // ********************************************************
  // Controller registers
  // ********************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_CMD    = 8'h08;
  localparam logic [7:0] REG_CODE   = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int         CTRL_GO    = 0;
  localparam int         CTRL_KIND  = 1;
  localparam int         CTRL_FLAG  = 3;
  localparam int         STAT_BUSY  = 0;
  localparam int         STAT_NACK  = 1;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_DEC   = 2'h3;

  typedef enum logic [1:0] {
    K_QUICK = 2'b00,
    K_SEND  = 2'b01,
    K_WORD  = 2'b10
  } sdwr_kind_t;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_RECV = 2'b01,
    D_ACK  = 2'b10
  } sdwr_dst_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b10,
    H_STOP  = 2'b11
  } sdwr_hst_t;

endpackage : sdwr_pkg

// ==== test/sdwr_monitor.sv ====
/*
 * Checker for the converter write link: follows frames on the wires
 * and ties the receiver outputs to them.
 * Assumes one clock domain and RST asynchronous, active high.
 */
`timescale 1ns/1ps
module sdwr_monitor
  import sdwr_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEF
) (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       sda_d_oe,
  input wire logic [9:0] CODE,
  input wire logic       PWRDN,
  input wire logic       BGREF
);
  // ********************************************************
  // Frame tracker
  // ********************************************************
  typedef struct packed {
    logic [3:0] bitc;
    logic [3:0] fall;
    logic [2:0] nb;
    logic       own;
    logic       sy;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] lo;
    logic [9:0] code;
  } sdwr_trk_t;

  sdwr_trk_t t_r;
  sdwr_trk_t t_nxt;
  logic      scl_q;
  logic      sda_q;
  logic      rise;
  logic      start_c;
  logic      stop_c;
  logic      ack_rise;

  assign rise     = scl & ~scl_q;
  assign start_c  = scl & scl_q & sda_q & ~sda;
  assign stop_c   = scl & scl_q & ~sda_q & sda;
  assign ack_rise = rise & (t_r.bitc == 4'h8);

  always_comb begin
    t_nxt = t_r;
    t_nxt.fall = (scl_q & ~scl) ? 4'h0 : ((t_r.fall == 4'hf) ? t_r.fall : t_r.fall + 4'h1);
    if (start_c || stop_c) begin
      t_nxt.bitc = 4'h0;
      t_nxt.nb = 3'h0;
      t_nxt.own = 1'h0;
    end else if (rise && !ack_rise) begin
      t_nxt.sh = {t_r.sh[6:0], sda};
      t_nxt.bitc = t_r.bitc + 4'h1;
    end else if (ack_rise) begin
      t_nxt.bitc = 4'h0;
      // A refused byte parks the count so later bytes are never taken
      t_nxt.nb = (!sda && t_r.nb != 3'h7) ? t_r.nb + 3'h1 : 3'h7;
      if (!sda) begin
        case (t_r.nb)
          3'h0: begin
            t_nxt.own = (t_r.sh == {OWN_ADDR, 1'h0});
            if (t_r.sh == {SYNC_ADDR, 1'h0}) begin
              t_nxt.sy = 1'h0;
              t_nxt.code = CODE_RST;
            end
          end
          3'h1: if (t_r.own) begin
            t_nxt.cmd = t_r.sh;
            t_nxt.sy = t_r.sh[0];
          end
          3'h2: t_nxt.lo = t_r.sh;
          3'h3: if (t_r.own) begin
            t_nxt.code = {t_r.sh[1:0], t_r.lo};
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      t_r <= '0;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      t_r <= t_nxt;
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // ********************************************************
  // Properties
  // ********************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_applied;
    ##[1:8] (CODE == t_r.code && PWRDN == t_r.cmd[CMD_SD] && BGREF == t_r.cmd[CMD_BG]);
  endsequence
  sequence s_frozen;
    ##1 $stable(CODE) [*8];
  endsequence

  property p_ack_window;
    $changed(sda_d_oe) |-> (!scl && t_r.fall <= 4'h5);
  endproperty
  property p_ack_stands;
    $rose(scl) && sda_d_oe |-> sda_d_oe [*8];
  endproperty
  property p_own_ack;
    ack_rise && t_r.nb == 3'h0 && t_r.sh == {OWN_ADDR, 1'h0} |-> !sda;
  endproperty
  property p_sync_ack;
    ack_rise && t_r.nb == 3'h0 && t_r.sh[7:1] == SYNC_ADDR |-> !sda;
  endproperty
  property p_word_stop;
    stop_c && t_r.own && t_r.nb == 3'h4 && !t_r.sy |-> s_applied;
  endproperty
  property p_short_stop;
    stop_c && t_r.own && (t_r.nb == 3'h2 || t_r.nb == 3'h3) && !t_r.sy |-> s_applied;
  endproperty
  property p_sy_hold;
    stop_c && t_r.own && t_r.nb >= 3'h2 && t_r.sy |-> s_frozen;
  endproperty
  property p_sync_update;
    ack_rise && t_r.nb == 3'h0 && t_r.sh == {SYNC_ADDR, 1'h1} && t_r.sy |-> ##[1:8] (CODE == t_r.code);
  endproperty
  property p_sync_clear;
    ack_rise && t_r.nb == 3'h0 && t_r.sh == {SYNC_ADDR, 1'h0} |-> ##[1:8] (CODE == CODE_RST && !PWRDN && !BGREF);
  endproperty

  a_ack_window: assert property (p_ack_window) else $error("ack driven outside its window");
  a_ack_stands: assert property (p_ack_stands) else $error("ack released while clock high");
  a_own_ack: assert property (p_own_ack) else $error("own address not acknowledged");
  a_sync_ack: assert property (p_sync_ack) else $error("sync address not acknowledged");
  a_word_stop: assert property (p_word_stop) else $error("word write not applied at stop");
  a_short_stop: assert property (p_short_stop) else $error("command only write misapplied");
  a_sy_hold: assert property (p_sy_hold) else $error("output moved at stop in sync mode");
  a_sync_update: assert property (p_sync_update) else $error("sync update not applied");
  a_sync_clear: assert property (p_sync_clear) else $error("sync clear not applied");
endmodule : sdwr_monitor

// ==== test/tb_top.sv ====
/*
 * Bench for the converter write link: drives the controller over
 * AXI4-Lite and checks the receiver outputs after each frame.
 * Assumes the package bit period; frames take thousands of cycles.
 */
`timescale 1ns/1ps
module tb_top
  import sdwr_pkg::*;
;
  localparam int TMO = 350000;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, pwrdn, bgref;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [9:0]  code;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #2.5 clk = ~clk;

  sdwr_if u_bus ();
  sdwr_host u_sdwr_host (.CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .BUS(u_bus));
  sdwr_device #(.OWN_ADDR(OWN_ADDR_DEF)) u_sdwr_device (.CLK(clk), .RST(rst), .BUS(u_bus),
    .CODE(code), .PWRDN(pwrdn), .BGREF(bgref));
  sdwr_monitor #(.OWN_ADDR(OWN_ADDR_DEF)) u_sdwr_monitor (.CLK(clk), .RST(rst), .scl(u_bus.scl),
    .sda(u_bus.sda), .sda_d_oe(u_bus.sda_d_oe), .CODE(code), .PWRDN(pwrdn), .BGREF(bgref));

  // ********************************************************
  // Tasks
  // ********************************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge clk); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd

  // Busy may lag the go write, so polling starts a few cycles later
  task automatic frame(input logic [31:0] ctrl);
    logic [31:0] d;
    logic [1:0]  r;
    wr(REG_CTRL, ctrl, r);
    repeat (4) @(posedge clk);
    do rd(REG_STATUS, d, r); while (d[STAT_BUSY] !== 1'h0);
    chk("nack", {31'h0, d[STAT_NACK]}, 32'h0);
    repeat (16) @(posedge clk);
    chk("scl idle", {31'h0, u_bus.scl}, 32'h1);
    chk("sda idle", {31'h0, u_bus.sda}, 32'h1);
  endtask : frame

  // ********************************************************
  // Tests
  // ********************************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    rd(REG_TARGET, d, r);
    chk("target reset", d, {25'h0, OWN_ADDR_DEF});
    rd(8'h14, d, r);
    chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_DEC});
    chk("unmapped rdata", d, 32'h0);
    wr(8'h14, 32'h1, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_DEC});
    wr(REG_CODE, 32'h1a5, r);
    chk("code bresp", {30'h0, r}, {30'h0, RESP_OKAY});
    rd(REG_CODE, d, r);
    chk("code reg", d, 32'h1a5);
    chk("code reset", {22'h0, code}, {22'h0, CODE_RST});
    $display("test registers done");
    wr(REG_CMD, 32'h4, r);
    frame(32'h5);
    chk("word code", {22'h0, code}, 32'h1a5);
    chk("word bgref", {31'h0, bgref}, 32'h1);
    chk("word pwrdn", {31'h0, pwrdn}, 32'h0);
    $display("test word write done");
    wr(REG_CMD, 32'h1, r);
    wr(REG_CODE, 32'h2da, r);
    frame(32'h5);
    chk("sync mode code", {22'h0, code}, 32'h1a5);
    $display("test sync mode write done");
    frame(32'h9);
    chk("sync update code", {22'h0, code}, 32'h2da);
    $display("test sync update done");
    wr(REG_CMD, 32'h2, r);
    frame(32'h3);
    chk("send byte code", {22'h0, code}, 32'h2da);
    chk("send byte pwrdn", {31'h0, pwrdn}, 32'h1);
    chk("send byte bgref", {31'h0, bgref}, 32'h0);
    $display("test send byte done");
    frame(32'h1);
    chk("clear code", {22'h0, code}, {22'h0, CODE_RST});
    chk("clear pwrdn", {31'h0, pwrdn}, 32'h0);
    chk("clear bgref", {31'h0, bgref}, 32'h0);
    $display("test sync clear done");
    stop_test();
  end
endmodule : tb_top
